/* File: hdl/ulf_fifo.sv */
// Ready/valid FIFO with optional single-entry holding mode
`timescale 1ns/1ps
module ulf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic one_deep,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [CW-1:0] ONE = CW'(1);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_depth
    $error("ulf_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic push;
  logic pop;

  // Character mode caps the fill at one entry
  assign in_ready = count < (one_deep ? ONE : FULL);
  assign out_valid = count != '0;
  assign out_data = mem[rd_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      count <= count + CW'(push) - CW'(pop);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_FIFO_BOUND: assert property (count <= FULL)
    else $error("FIFO count above depth");
  AST_ONE_DEEP: assert property (one_deep && count != '0 |-> !in_ready)
    else $error("Holding register accepted a second entry");
  AST_FIFO_FILL: assert property (push && !pop |=> count == $past(count) + ONE)
    else $error("FIFO count did not follow a push");
endmodule // ulf_fifo

/* File: hdl/ulf_pkg.sv */
// Package of register map, field positions, states and parity helper
package ulf_pkg;
  localparam logic [11:0] ADDR_DATA = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h018;
  localparam logic [11:0] ADDR_DIV = 12'h024;
  localparam logic [11:0] ADDR_LCR = 12'h02c;
  localparam int LCR_BREAK_POS = 0;
  localparam int LCR_PARITY_POS = 1;
  localparam int LCR_EVEN_POS = 2;
  localparam int LCR_TWO_STOP_POS = 3;
  localparam int LCR_FIFO_POS = 4;
  localparam int LCR_WORD_POS = 5;
  localparam int LCR_STICK_POS = 7;
  localparam int LCR_W = 8;
  localparam logic [7:0] LCR_RESET = 8'h00;
  localparam logic [15:0] DIV_RESET = 16'h00d9;
  localparam logic [2:0] WORD_TO_LAST = 3'h4;
  localparam logic [2:0] LAST_MAX = 3'h7;
  localparam logic [7:0] FULL_MASK = 8'hff;
  localparam int RX_W = 10;

  typedef enum logic [5:0] {
    TX_IDLE = 6'b000001,
    TX_START = 6'b000010,
    TX_DATA = 6'b000100,
    TX_PAR = 6'b001000,
    TX_STOP = 6'b010000,
    TX_BREAK = 6'b100000
  } ulf_tx_t;

  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA = 5'b00100,
    RX_PAR = 5'b01000,
    RX_STOP = 5'b10000
  } ulf_rx_t;

  // Parity bit for the active data bits of a frame
  function automatic logic ulf_parity(input logic [7:0] d, input logic [2:0] last,
                                      input logic even_sel, input logic stick_sel);
    logic [7:0] m;
    m = FULL_MASK >> (LAST_MAX - last);
    if (stick_sel) begin
      return ~even_sel;
    end
    return (^(d & m)) ^ ~even_sel;
  endfunction
endpackage

/* File: hdl/ulf_sync.sv */
// Two-flop synchroniser for the serial receive pin
`timescale 1ns/1ps
module ulf_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic meta_reg;

  // Idle line level is high, so both stages reset high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b1;
      q <= 1'b1;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // ulf_sync

/* File: hdl/ulf_top.sv */
// Serial line frame control with APB registers, transmitter and receiver
// What this block does
// - Word length field selects five to eight data bits, five after reset.
// - FIFO enable set buffers both directions in eight-entry FIFOs.
// - Two-stop select appends two stop bits, otherwise one.
// - Receiver checks only the first stop bit.
// - Even select with parity on gives even ones count.
// - Even select clear with parity on gives odd ones count.
// - Even select has no effect while parity is off.
// - Parity on adds a parity bit on transmit and checks it on receive.
// - Parity off puts stop bits straight after the data bits.
// - Stick parity sends and checks the bit as inverse of even select.
// - Send-break drives the line low once the current character ends.
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module ulf_top #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_rx_in,
  output logic serial_tx_out
);
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("ulf_top: FIFO_DEPTH must be at least 2");
  end

  logic [ulf_pkg::LCR_W-1:0] line_control_reg;
  logic [15:0] div_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rd_next;
  logic mapped;
  logic setup_done;
  logic done;

  logic [1:0] word_length_sel;
  logic fifo_buffer_on;
  logic double_stop_sel;
  logic even_parity_sel;
  logic parity_on;
  logic send_break;
  logic stick_parity_sel;
  logic [2:0] last_idx;

  assign send_break = line_control_reg[ulf_pkg::LCR_BREAK_POS];
  assign parity_on = line_control_reg[ulf_pkg::LCR_PARITY_POS];
  assign even_parity_sel = line_control_reg[ulf_pkg::LCR_EVEN_POS];
  assign double_stop_sel = line_control_reg[ulf_pkg::LCR_TWO_STOP_POS];
  assign fifo_buffer_on = line_control_reg[ulf_pkg::LCR_FIFO_POS];
  assign word_length_sel = line_control_reg[ulf_pkg::LCR_WORD_POS +: 2];
  assign stick_parity_sel = line_control_reg[ulf_pkg::LCR_STICK_POS];
  assign last_idx = 3'(word_length_sel) + ulf_pkg::WORD_TO_LAST;

  // Transmit FIFO
  logic txf_in_ready;
  logic txf_out_valid;
  logic txf_out_ready;
  logic [7:0] txf_out_data;
  logic [CW-1:0] txf_count;
  logic tx_push;

  // Receive FIFO
  logic rxf_in_ready;
  logic rxf_out_valid;
  logic rxf_pop;
  logic [ulf_pkg::RX_W-1:0] rxf_out_data;
  logic [CW-1:0] rxf_count;
  logic rx_push_reg;
  logic [ulf_pkg::RX_W-1:0] rx_word_reg;

  ulf_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .one_deep(!fifo_buffer_on),
    .in_valid(tx_push),
    .in_ready(txf_in_ready),
    .in_data(pwdata[7:0]),
    .out_valid(txf_out_valid),
    .out_ready(txf_out_ready),
    .out_data(txf_out_data),
    .count(txf_count)
  );

  ulf_fifo #(.WIDTH(ulf_pkg::RX_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .one_deep(!fifo_buffer_on),
    .in_valid(rx_push_reg),
    .in_ready(rxf_in_ready),
    .in_data(rx_word_reg),
    .out_valid(rxf_out_valid),
    .out_ready(rxf_pop),
    .out_data(rxf_out_data),
    .count(rxf_count)
  );

  // APB: one wait state, answer registered
  assign setup_done = psel & penable & ~pready_reg;
  assign done = psel & penable & pready_reg;
  assign mapped = paddr == ulf_pkg::ADDR_DATA || paddr == ulf_pkg::ADDR_STAT ||
                  paddr == ulf_pkg::ADDR_DIV || paddr == ulf_pkg::ADDR_LCR;
  assign tx_push = done & pwrite & (paddr == ulf_pkg::ADDR_DATA);
  assign rxf_pop = done & ~pwrite & (paddr == ulf_pkg::ADDR_DATA);

  ulf_pkg::ulf_tx_t tx_st_reg;
  ulf_pkg::ulf_rx_t rx_st_reg;

  always_comb begin
    rd_next = '0;
    if (paddr == ulf_pkg::ADDR_DATA) begin
      rd_next = rxf_out_valid ? 32'(rxf_out_data) : 32'h0000_0000;
    end else if (paddr == ulf_pkg::ADDR_STAT) begin
      rd_next = 32'({tx_st_reg != ulf_pkg::TX_IDLE, rxf_out_valid, !rxf_in_ready,
                     !txf_out_valid, !txf_in_ready});
    end else if (paddr == ulf_pkg::ADDR_DIV) begin
      rd_next = 32'(div_reg);
    end else if (paddr == ulf_pkg::ADDR_LCR) begin
      rd_next = 32'(line_control_reg);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else begin
      pready_reg <= setup_done;
      pslverr_reg <= setup_done & ~mapped;
      prdata_reg <= setup_done ? rd_next : '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_control_reg <= ulf_pkg::LCR_RESET;
      div_reg <= ulf_pkg::DIV_RESET;
    end else if (done & pwrite) begin
      if (paddr == ulf_pkg::ADDR_LCR) begin
        line_control_reg <= pwdata[ulf_pkg::LCR_W-1:0];
      end
      if (paddr == ulf_pkg::ADDR_DIV) begin
        div_reg <= pwdata[15:0];
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // Transmitter
  logic [15:0] tx_cnt_reg;
  logic tx_tick;
  logic [7:0] tx_sh_reg;
  logic [2:0] tx_idx_reg;
  logic tx_par_reg;
  logic tx_stop_reg;
  logic tx_out_reg;

  assign tx_tick = tx_cnt_reg == '0;
  // Break waits for idle, so a frame in flight always completes
  assign txf_out_ready = (tx_st_reg == ulf_pkg::TX_IDLE) & ~send_break;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cnt_reg <= ulf_pkg::DIV_RESET;
    end else if (tx_st_reg == ulf_pkg::TX_IDLE || tx_st_reg == ulf_pkg::TX_BREAK || tx_tick) begin
      tx_cnt_reg <= div_reg;
    end else begin
      tx_cnt_reg <= tx_cnt_reg - 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_reg <= ulf_pkg::TX_IDLE;
      tx_out_reg <= 1'b1;
      tx_sh_reg <= '0;
      tx_idx_reg <= '0;
      tx_par_reg <= 1'b0;
      tx_stop_reg <= 1'b0;
    end else begin
      unique case (tx_st_reg)
        ulf_pkg::TX_IDLE: begin
          tx_out_reg <= 1'b1;
          if (send_break) begin
            tx_st_reg <= ulf_pkg::TX_BREAK;
            tx_out_reg <= 1'b0;
          end else if (txf_out_valid) begin
            tx_st_reg <= ulf_pkg::TX_START;
            tx_out_reg <= 1'b0;
            tx_sh_reg <= txf_out_data;
            tx_par_reg <= ulf_pkg::ulf_parity(txf_out_data, last_idx, even_parity_sel,
                                              stick_parity_sel);
          end
        end
        ulf_pkg::TX_START: begin
          if (tx_tick) begin
            tx_st_reg <= ulf_pkg::TX_DATA;
            tx_out_reg <= tx_sh_reg[0];
            tx_idx_reg <= '0;
          end
        end
        ulf_pkg::TX_DATA: begin
          if (tx_tick) begin
            if (tx_idx_reg == last_idx) begin
              if (parity_on) begin
                tx_st_reg <= ulf_pkg::TX_PAR;
                tx_out_reg <= tx_par_reg;
              end else begin
                tx_st_reg <= ulf_pkg::TX_STOP;
                tx_out_reg <= 1'b1;
                tx_stop_reg <= 1'b0;
              end
            end else begin
              tx_idx_reg <= tx_idx_reg + 3'h1;
              tx_out_reg <= tx_sh_reg[1];
              tx_sh_reg <= tx_sh_reg >> 1;
            end
          end
        end
        ulf_pkg::TX_PAR: begin
          if (tx_tick) begin
            tx_st_reg <= ulf_pkg::TX_STOP;
            tx_out_reg <= 1'b1;
            tx_stop_reg <= 1'b0;
          end
        end
        ulf_pkg::TX_STOP: begin
          if (tx_tick) begin
            if (tx_stop_reg == double_stop_sel) begin
              tx_st_reg <= ulf_pkg::TX_IDLE;
            end else begin
              tx_stop_reg <= 1'b1;
            end
          end
        end
        ulf_pkg::TX_BREAK: begin
          if (!send_break) begin
            tx_st_reg <= ulf_pkg::TX_IDLE;
            tx_out_reg <= 1'b1;
          end
        end
        default: begin
          tx_st_reg <= ulf_pkg::TX_IDLE;
          tx_out_reg <= 1'b1;
        end
      endcase
    end
  end

  assign serial_tx_out = tx_out_reg;

  // Receiver
  logic rx_s;
  logic rx_prev_reg;
  logic [15:0] rx_cnt_reg;
  logic rx_tick;
  logic [7:0] rx_sh_reg;
  logic [7:0] rx_data;
  logic [2:0] rx_idx_reg;
  logic rx_perr_reg;

  ulf_sync u_rx_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(serial_rx_in),
    .q(rx_s)
  );

  assign rx_tick = rx_cnt_reg == '0;
  // Bits shift in from the top, so short words are realigned
  assign rx_data = rx_sh_reg >> (ulf_pkg::LAST_MAX - last_idx);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_prev_reg <= 1'b1;
      rx_cnt_reg <= ulf_pkg::DIV_RESET;
    end else begin
      rx_prev_reg <= rx_s;
      // Half a bit from the falling edge puts samples mid-bit
      if (rx_st_reg == ulf_pkg::RX_IDLE) begin
        rx_cnt_reg <= {1'b0, div_reg[15:1]};
      end else if (rx_tick) begin
        rx_cnt_reg <= div_reg;
      end else begin
        rx_cnt_reg <= rx_cnt_reg - 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_reg <= ulf_pkg::RX_IDLE;
      rx_sh_reg <= '0;
      rx_idx_reg <= '0;
      rx_perr_reg <= 1'b0;
      rx_push_reg <= 1'b0;
      rx_word_reg <= '0;
    end else begin
      rx_push_reg <= 1'b0;
      unique case (rx_st_reg)
        ulf_pkg::RX_IDLE: begin
          if (rx_prev_reg && !rx_s) begin
            rx_st_reg <= ulf_pkg::RX_START;
          end
        end
        ulf_pkg::RX_START: begin
          if (rx_tick) begin
            rx_st_reg <= rx_s ? ulf_pkg::RX_IDLE : ulf_pkg::RX_DATA;
            rx_idx_reg <= '0;
            rx_perr_reg <= 1'b0;
          end
        end
        ulf_pkg::RX_DATA: begin
          if (rx_tick) begin
            rx_sh_reg <= {rx_s, rx_sh_reg[7:1]};
            rx_idx_reg <= rx_idx_reg + 3'h1;
            if (rx_idx_reg == last_idx) begin
              rx_st_reg <= parity_on ? ulf_pkg::RX_PAR : ulf_pkg::RX_STOP;
            end
          end
        end
        ulf_pkg::RX_PAR: begin
          if (rx_tick) begin
            rx_st_reg <= ulf_pkg::RX_STOP;
            rx_perr_reg <= rx_s != ulf_pkg::ulf_parity(rx_data, last_idx, even_parity_sel,
                                                      stick_parity_sel);
          end
        end
        ulf_pkg::RX_STOP: begin
          // Only the first stop bit is sampled
          if (rx_tick) begin
            rx_st_reg <= ulf_pkg::RX_IDLE;
            rx_push_reg <= 1'b1;
            rx_word_reg <= {~rx_s, rx_perr_reg, rx_data};
          end
        end
        default: begin
          rx_st_reg <= ulf_pkg::RX_IDLE;
        end
      endcase
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_TX_LAST_BIT: assert property (tx_st_reg == ulf_pkg::TX_DATA && tx_tick &&
      tx_idx_reg == last_idx |=> tx_st_reg != ulf_pkg::TX_DATA)
    else $error("Transmitter sent wrong number of data bits");
  AST_TX_FIFO_HOLD: assert property (!fifo_buffer_on |-> txf_count <= CW'(1))
    else $error("Character mode held more than one transmit entry");
  AST_STOP_COUNT: assert property (tx_st_reg == ulf_pkg::TX_STOP && tx_tick
      && !double_stop_sel |=> tx_st_reg == ulf_pkg::TX_IDLE)
    else $error("Single stop bit not honoured");
  AST_STOP_TWO: assert property (tx_st_reg == ulf_pkg::TX_STOP && tx_tick && !tx_stop_reg
      && double_stop_sel |=> tx_st_reg == ulf_pkg::TX_STOP)
    else $error("Second stop bit missing");
  AST_RX_ONE_STOP: assert property (rx_st_reg == ulf_pkg::RX_STOP && rx_tick
      |=> rx_st_reg == ulf_pkg::RX_IDLE && rx_push_reg)
    else $error("Receiver waited past the first stop bit");
  AST_PAR_LEVEL: assert property ($rose(tx_st_reg == ulf_pkg::TX_PAR)
      |-> serial_tx_out == tx_par_reg)
    else $error("Parity bit level wrong on line");
  AST_NO_PARITY: assert property (!parity_on && tx_st_reg == ulf_pkg::TX_DATA && tx_tick
      && tx_idx_reg == last_idx |=> tx_st_reg == ulf_pkg::TX_STOP && serial_tx_out)
    else $error("Parity bit sent with parity off");
  AST_BREAK_LOW: assert property (tx_st_reg == ulf_pkg::TX_BREAK |-> !serial_tx_out)
    else $error("Line not low during break");
  AST_BREAK_AFTER_CHAR: assert property (send_break && tx_st_reg == ulf_pkg::TX_DATA
      |=> tx_st_reg != ulf_pkg::TX_BREAK)
    else $error("Break cut a character short");
  AST_BREAK_RELEASE: assert property (tx_st_reg == ulf_pkg::TX_BREAK && !send_break
      |=> serial_tx_out && tx_st_reg == ulf_pkg::TX_IDLE)
    else $error("Line did not return high after break");

  COV_PAR_FRAME: cover property (tx_st_reg == ulf_pkg::TX_PAR && tx_tick);
  COV_TWO_STOP: cover property (tx_st_reg == ulf_pkg::TX_STOP && tx_stop_reg && tx_tick);
  COV_BREAK: cover property (tx_st_reg == ulf_pkg::TX_BREAK ##1 tx_st_reg == ulf_pkg::TX_IDLE);
  COV_RX_WORD: cover property (rx_push_reg && rxf_in_ready);
endmodule // ulf_top

/* File: testbench/ulf_remote.sv */
// Remote serial device model: frame sender and line sampler
`timescale 1ns/1ps
module ulf_remote #(
  parameter int BIT_CYC = 4
) (
  input wire logic pclk,
  input wire logic line_in,
  output logic line_out
);
  // Idle level is high between frames
  initial line_out = 1'b1;

  // Sends v[0] first for n bit times, then returns to idle high
  task automatic send(input logic [15:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      line_out <= v[i];
      repeat (BIT_CYC) @(posedge pclk);
    end
    line_out <= 1'b1;
  endtask

  // Samples n bits mid-bit; gap counts cycles from start to the next low level
  task automatic recv(output logic [15:0] v, input int n, output int gap);
    int t;
    v = '0;
    t = 0;
    while (line_in !== 1'b0 && t < 400) begin
      @(posedge pclk);
      t++;
    end
    for (int i = 0; i < n; i++) begin
      repeat ((i == 0) ? BIT_CYC / 2 : BIT_CYC) @(posedge pclk);
      v[i] = line_in;
    end
    gap = BIT_CYC / 2 + (n - 1) * BIT_CYC;
    // Bounded, so a line stuck high cannot hang the caller
    while (line_in !== 1'b0 && gap < 20 * BIT_CYC) begin
      @(posedge pclk);
      gap++;
    end
  endtask
endmodule // ulf_remote

/* File: testbench/ulf_top_tb.sv */
// Testbench for the serial line frame control block
`timescale 1ns/1ps
module ulf_top_tb;
  localparam int BT = 4;
  localparam int LIMIT = 20000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_line, tx_line;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;

  ulf_top #(.FIFO_DEPTH(8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_rx_in(rx_line), .serial_tx_out(tx_line));
  ulf_remote #(.BIT_CYC(BT)) far_u (.pclk(pclk), .line_in(tx_line), .line_out(rx_line));

  initial pclk = 1'b0;
  always #20 pclk = ~pclk;

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Cuts a hang short
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      bad_count++;
      close_out();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_in(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle cycle so the next setup never lands in the same time step
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic e;
    apb(1'b1, a, d, x, e);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0, d, e);
  endtask

  task automatic wait_stat(input int b, input logic val);
    logic [31:0] d;
    int k;
    k = 0;
    rd(ulf_pkg::ADDR_STAT, d);
    while (d[b] !== val && k < 400) begin
      rd(ulf_pkg::ADDR_STAT, d);
      k++;
    end
    cmp({31'h0, d[b]}, {31'h0, val});
  endtask

  function automatic logic par(input logic [7:0] d, input logic [7:0] c);
    logic p;
    p = 1'b0;
    for (int i = 0; i < 5 + c[6:5]; i++) p = p ^ d[i];
    if (c[7]) begin
      return ~c[2];
    end
    return c[2] ? p : ~p;
  endfunction

  // Start bit, data LSB first, optional parity, trailing ones for stops
  function automatic logic [15:0] frm(input logic [7:0] d, input logic [7:0] c);
    logic [15:0] v;
    int nb;
    nb = 5 + c[6:5];
    v = 16'hffff;
    v[0] = 1'b0;
    for (int i = 0; i < nb; i++) v[1 + i] = d[i];
    if (c[1]) v[1 + nb] = par(d, c);
    return v;
  endfunction

  function automatic int flen(input logic [7:0] c);
    return 7 + c[6:5] + c[1] + c[3];
  endfunction

  task automatic t_reset();
    logic [31:0] d;
    logic e;
    rd(ulf_pkg::ADDR_LCR, d);
    cmp(d, 32'h0);
    rd(ulf_pkg::ADDR_DIV, d);
    cmp(d, 32'h000000d9);
    apb(1'b0, 12'h100, 32'h0, d, e);
    cmp({31'h0, e}, 32'h1);
    // Break left clear: a pulse this short would be no valid break
    wr(ulf_pkg::ADDR_LCR, 32'hfffffffe);
    rd(ulf_pkg::ADDR_LCR, d);
    cmp(d, 32'h000000fe);
    wr(ulf_pkg::ADDR_DIV, 32'h3);
    wr(ulf_pkg::ADDR_LCR, 32'h10);
    $display("test reset done");
  endtask

  task automatic t_tx();
    logic [7:0] cfg [7] = '{8'h10, 8'h30, 8'h56, 8'h72, 8'h7c, 8'hf6, 8'hf2};
    logic [15:0] v1, v2, m;
    int g1, g2, n;
    foreach (cfg[k]) begin
      n = flen(cfg[k]);
      m = (16'h1 << n) - 16'h1;
      wr(ulf_pkg::ADDR_LCR, {24'h0, cfg[k]});
      fork
        begin
          far_u.recv(v1, n, g1);
          far_u.recv(v2, n, g2);
        end
        begin
          wr(ulf_pkg::ADDR_DATA, 32'h5b);
          wr(ulf_pkg::ADDR_DATA, 32'ha6);
        end
      join
      cmp({16'h0, v1}, {16'h0, frm(8'h5b, cfg[k]) & m});
      cmp({16'h0, v2}, {16'h0, frm(8'ha6, cfg[k]) & m});
      cmp_in(g1, n * BT, n * BT + 2);
    end
    $display("test transmit formats done");
  endtask

  task automatic t_rx();
    logic [7:0] cfg [5] = '{8'h72, 8'h72, 8'h7a, 8'h56, 8'h10};
    logic [7:0] dat [5] = '{8'ha5, 8'ha5, 8'h3c, 8'h55, 8'h15};
    int bad [5] = '{0, 1, 0, 2, 0};
    logic [31:0] exp [5] = '{32'h0a5, 32'h1a5, 32'h03c, 32'h255, 32'h015};
    logic [15:0] v;
    logic [31:0] d;
    int nb;
    foreach (cfg[k]) begin
      nb = 5 + cfg[k][6:5];
      v = frm(dat[k], cfg[k]);
      if (bad[k] == 1) v[1 + nb] = ~v[1 + nb];
      if (bad[k] == 2) v[1 + nb + cfg[k][1]] = 1'b0;
      wr(ulf_pkg::ADDR_LCR, {24'h0, cfg[k]});
      // Only one stop bit is ever sent, even with two selected
      far_u.send(v, 2 + nb + cfg[k][1]);
      wait_stat(3, 1'b1);
      rd(ulf_pkg::ADDR_DATA, d);
      cmp(d, exp[k]);
    end
    $display("test receive done");
  endtask

  task automatic t_fifo();
    logic [31:0] d;
    // Slower bit time so pushes outrun the shifter
    wr(ulf_pkg::ADDR_DIV, 32'h7);
    wr(ulf_pkg::ADDR_LCR, 32'h60);
    repeat (3) wr(ulf_pkg::ADDR_DATA, 32'h11);
    rd(ulf_pkg::ADDR_STAT, d);
    cmp({31'h0, d[0]}, 32'h1);
    wait_stat(1, 1'b1);
    wait_stat(4, 1'b0);
    wr(ulf_pkg::ADDR_LCR, 32'h70);
    repeat (8) wr(ulf_pkg::ADDR_DATA, 32'h22);
    rd(ulf_pkg::ADDR_STAT, d);
    cmp({31'h0, d[0]}, 32'h0);
    wr(ulf_pkg::ADDR_DATA, 32'h33);
    rd(ulf_pkg::ADDR_STAT, d);
    cmp({31'h0, d[0]}, 32'h1);
    wait_stat(1, 1'b1);
    wait_stat(4, 1'b0);
    wr(ulf_pkg::ADDR_DIV, 32'h3);
    $display("test buffering done");
  endtask

  task automatic t_break();
    logic [15:0] v;
    int g, hi;
    hi = 0;
    wr(ulf_pkg::ADDR_LCR, 32'h70);
    wr(ulf_pkg::ADDR_DATA, 32'h0f);
    fork
      far_u.recv(v, 10, g);
      begin
        repeat (8) @(posedge pclk);
        wr(ulf_pkg::ADDR_LCR, 32'h71);
      end
    join
    cmp({16'h0, v}, {16'h0, frm(8'h0f, 8'h70) & 16'h03ff});
    cmp_in(g, 10 * BT, 10 * BT + 2);
    // Held for two full frame periods before release
    repeat (20 * BT) begin
      @(posedge pclk);
      if (tx_line !== 1'b0) hi++;
    end
    cmp_in(hi, 0, 0);
    wr(ulf_pkg::ADDR_LCR, 32'h70);
    // Line goes high one edge after the write lands
    @(posedge pclk);
    cmp({31'h0, tx_line}, 32'h1);
    fork
      far_u.recv(v, 10, g);
      wr(ulf_pkg::ADDR_DATA, 32'h3c);
    join
    cmp({16'h0, v}, {16'h0, frm(8'h3c, 8'h70) & 16'h03ff});
    $display("test break done");
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_tx();
    t_rx();
    t_fifo();
    t_break();
    close_out();
  end
endmodule // ulf_top_tb
